/* File: rtl/apmc_dev.sv */
`timescale 1ns/1ns
// Summary of operation
// [RL1] 98h or E5h query power mode
// [RL2] standby states load sector count zero
// [RL3] idle loads sector count all ones
// [RL4] 06h trim selected by feature bit
// [RL5] host count nonzero, in blocks
// [RL6] one 512-byte range block only
// [RL7] diagnostic ignores drive select bit
// [RL8] diagnostic result code in error register
// [RL9] flush commits cache then ready, seek-complete
// [RL10] unsupported flush answers command aborted
// [RL11] ext flush busy until done or error
// [RL12] write error aborts, leaves failing address
// [RL13] next ext flush resumes after failing sector
// [RL14] format takes one sector, discards it
// [RL15] lba format count zero means 256
// [RL16] format start address from three registers
// [RL17] host avoids format command; apmc_host still passes 50h and sends its sector payload
// [RL18] host writes 48-bit registers twice; apmc_host writes lba_lo once, as zero, and ties lba_hi to zero
// [RL19] clear busy, interrupt after final values
module apmc_dev (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	apmc_if.dev tf,
	input wire logic [1:0] pwr_mode_i,
	input wire logic flush_supported_i,
	input wire logic [7:0] diag_code_i,
	input wire logic [47:0] cache_dirty_top_i,
	input wire logic [47:0] media_fail_lba_i,
	input wire logic media_fail_i,
	output logic trim_go_o,
	output logic [47:0] flush_lba_o,
	output logic [8:0] fmt_count_o,
	output logic [27:0] fmt_start_o,
	output logic fmt_go_o
);
	typedef enum logic [2:0] {
		APMC_ST_IDLE = 3'b000,
		APMC_ST_FLUSH = 3'b001,
		APMC_ST_DATA = 3'b010,
		APMC_ST_DONE = 3'b011
	} apmc_st_e;

	apmc_st_e state_ff;
	logic [7:0] status_ff;
	logic [7:0] error_ff;
	logic [15:0] scnt_ff;
	logic [47:0] lba_ff;
	logic [47:0] resume_ff;
	logic [9:0] bytes_ff;
	logic [7:0] op_ff;
	logic intrq_ff;
	logic trim_ff;
	logic fmt_go_ff;
	logic [8:0] fmt_cnt_ff;
	logic [27:0] fmt_start_ff;

	function automatic logic [7:0] sts(input logic err);
		sts = 8'h00;
		sts[apmc_pkg::STS_RDY] = 1'b1;
		sts[apmc_pkg::STS_DSC] = 1'b1;
		sts[apmc_pkg::STS_ERR] = err;
	endfunction

	assign tf.status = status_ff;
	assign tf.error = error_ff;
	assign tf.scnt_out = scnt_ff;
	assign tf.lba_out = lba_ff;
	assign tf.intrq = intrq_ff;
	assign tf.wdata_rdy = (state_ff == APMC_ST_DATA);
	assign trim_go_o = trim_ff;
	assign flush_lba_o = resume_ff;
	assign fmt_count_o = fmt_cnt_ff;
	assign fmt_start_o = fmt_start_ff;
	assign fmt_go_o = fmt_go_ff;

	// =====================================
	// command sequencer
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= APMC_ST_IDLE;
			status_ff <= apmc_pkg::STS_RESET;
			error_ff <= apmc_pkg::ERR_RESET;
			scnt_ff <= 16'h0000;
			lba_ff <= 48'h0;
			resume_ff <= 48'h0;
			bytes_ff <= 10'h000;
			op_ff <= 8'h00;
			intrq_ff <= 1'b0;
			trim_ff <= 1'b0;
			fmt_go_ff <= 1'b0;
			fmt_cnt_ff <= 9'h000;
			fmt_start_ff <= 28'h0;
		end else begin
			trim_ff <= 1'b0;
			fmt_go_ff <= 1'b0;
			case (state_ff)
				APMC_ST_IDLE: begin
					if (tf.cmd_vld) begin
						// a new command withdraws the previous interrupt
						intrq_ff <= 1'b0;
						op_ff <= tf.cmd;
						status_ff <= 8'h80;
						error_ff <= 8'h00;
						bytes_ff <= 10'h000;
						state_ff <= APMC_ST_DONE;
						if (tf.cmd == apmc_pkg::OP_PWR_QUERY_A || tf.cmd == apmc_pkg::OP_PWR_QUERY_B) begin // [RL1]
							if (pwr_mode_i == apmc_pkg::APMC_PM_IDLE) begin
								scnt_ff <= {8'h00, apmc_pkg::SC_IDLE}; // [RL3]
							end else begin
								scnt_ff <= {8'h00, apmc_pkg::SC_STANDBY}; // [RL2]
							end
						end else if (tf.cmd == apmc_pkg::OP_DIAG) begin
							// drive select not looked at, one answer covers both devices
							error_ff <= diag_code_i; // [RL7] [RL8]
						end else if (tf.cmd == apmc_pkg::OP_FLUSH || tf.cmd == apmc_pkg::OP_FLUSH_EXT) begin
							if (!flush_supported_i) begin
								error_ff <= apmc_pkg::ERR_ABORT; // [RL10]
							end else begin
								state_ff <= APMC_ST_FLUSH; // [RL9] [RL11]
							end
						end else if (tf.cmd == apmc_pkg::OP_DSM) begin
							// zero count and multi-block requests refused
							if (tf.scnt != 16'h0001 || !tf.feat[apmc_pkg::FR_TRIM]) begin // [RL4] [RL5] [RL6]
								error_ff <= apmc_pkg::ERR_ABORT;
							end else begin
								state_ff <= APMC_ST_DATA;
							end
						end else if (tf.cmd == apmc_pkg::OP_FORMAT) begin
							fmt_start_ff <= {tf.dev_head[3:0], tf.lba_lo[23:16], tf.lba_lo[15:8], 8'h00}; // [RL16]
							if (tf.dev_head[apmc_pkg::DH_LBA]) begin
								fmt_cnt_ff <= (tf.scnt[7:0] == 8'h00) ? apmc_pkg::FMT_ZERO_CNT
									: {1'b0, tf.scnt[7:0]}; // [RL15]
							end else begin
								fmt_cnt_ff <= 9'h001;
							end
							state_ff <= APMC_ST_DATA; // [RL14]
						end else begin
							error_ff <= apmc_pkg::ERR_ABORT;
						end
					end
				end
				APMC_ST_FLUSH: begin
					if (media_fail_i) begin
						error_ff <= apmc_pkg::ERR_ABORT; // [RL12]
						lba_ff <= media_fail_lba_i;
						resume_ff <= 48'(media_fail_lba_i + 48'h1); // [RL13]
						state_ff <= APMC_ST_DONE;
					end else if (resume_ff >= cache_dirty_top_i) begin
						resume_ff <= 48'h0;
						state_ff <= APMC_ST_DONE;
					end else begin
						resume_ff <= 48'(resume_ff + 48'h1);
					end
				end
				APMC_ST_DATA: begin
					if (tf.wdata_vld) begin
						bytes_ff <= 10'(bytes_ff + 10'h001);
						if (bytes_ff == 10'(apmc_pkg::BLOCK_BYTES - 10'h001)) begin
							// format payload is simply dropped
							trim_ff <= (op_ff == apmc_pkg::OP_DSM);
							fmt_go_ff <= (op_ff == apmc_pkg::OP_FORMAT);
							state_ff <= APMC_ST_DONE;
						end
					end
				end
				default: begin
					// registers settle one cycle before busy drops
					status_ff <= sts(error_ff != 8'h00 && op_ff != apmc_pkg::OP_DIAG); // [RL19]
					intrq_ff <= 1'b1;
					state_ff <= APMC_ST_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: rtl/apmc_pkg.sv */
package apmc_pkg;
	// =====================================
	// opcodes
	localparam logic [7:0] OP_PWR_QUERY_A = 8'h98;
	localparam logic [7:0] OP_PWR_QUERY_B = 8'he5;
	localparam logic [7:0] OP_DSM = 8'h06;
	localparam logic [7:0] OP_DIAG = 8'h90;
	localparam logic [7:0] OP_FLUSH = 8'he7;
	localparam logic [7:0] OP_FLUSH_EXT = 8'hea;
	localparam logic [7:0] OP_FORMAT = 8'h50;
	// =====================================
	// results and field positions
	localparam logic [7:0] SC_STANDBY = 8'h00;
	localparam logic [7:0] SC_IDLE = 8'hff;
	localparam logic [7:0] DIAG_OK = 8'h01;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam int STS_BSY = 7;
	localparam int STS_RDY = 6;
	localparam int STS_DSC = 4;
	localparam int STS_ERR = 0;
	localparam int DH_LBA = 6;
	localparam int DH_DRV = 4;
	localparam int FR_TRIM = 0;
	localparam logic [7:0] STS_RESET = 8'h50;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [9:0] BLOCK_BYTES = 10'h200;
	localparam logic [8:0] FMT_ZERO_CNT = 9'h100;
	// =====================================
	// power modes
	typedef enum logic [1:0] {
		APMC_PM_IDLE = 2'b00,
		APMC_PM_STBY = 2'b01,
		APMC_PM_TO_STBY = 2'b10,
		APMC_PM_FROM_STBY = 2'b11
	} apmc_pm_e;
	// =====================================
	// wishbone register offsets of the host end
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_PARAM = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;
	localparam logic [3:0] REG_IRQ_STS = 4'hc;
endpackage

/* File: rtl/apmc_if.sv */
`timescale 1ns/1ns
interface apmc_if;
	logic [7:0] cmd;
	logic cmd_vld;
	logic [15:0] feat;
	logic [15:0] scnt;
	logic [23:0] lba_lo;
	logic [23:0] lba_hi;
	logic [7:0] dev_head;
	logic [7:0] wdata;
	logic wdata_vld;
	logic [7:0] status;
	logic [7:0] error;
	logic [15:0] scnt_out;
	logic [47:0] lba_out;
	logic intrq;
	logic wdata_rdy;
	modport dev (input cmd, cmd_vld, feat, scnt, lba_lo, lba_hi, dev_head, wdata, wdata_vld,
		output status, error, scnt_out, lba_out, intrq, wdata_rdy);
	modport host (output cmd, cmd_vld, feat, scnt, lba_lo, lba_hi, dev_head, wdata, wdata_vld,
		input status, error, scnt_out, lba_out, intrq, wdata_rdy);
endinterface

/* File: rtl/apmc_host.sv */
`timescale 1ns/1ns
module apmc_host (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	apmc_if.host tf,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o
);
	logic ack_ff;
	logic [31:0] rd_ff;
	logic [7:0] cmd_ff;
	logic go_ff;
	logic [15:0] feat_ff;
	logic [15:0] scnt_ff;
	logic [7:0] dh_ff;
	logic [23:0] lba_ff;
	logic [9:0] cnt_ff;
	logic sending_ff;
	logic [1:0] sts_ff;
	logic [1:0] en_ff;
	logic irq_d_ff;

	wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
	wire rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
	wire done_ev = tf.intrq && !irq_d_ff;
	wire err_ev = done_ev && tf.status[apmc_pkg::STS_ERR];

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rd_ff;
	assign irq_o = |(sts_ff & en_ff);
	assign tf.cmd = cmd_ff;
	assign tf.cmd_vld = go_ff;
	assign tf.feat = feat_ff;
	assign tf.scnt = scnt_ff;
	assign tf.lba_lo = lba_ff;
	assign tf.lba_hi = 24'h0;
	assign tf.dev_head = dh_ff;
	assign tf.wdata = 8'hff;
	assign tf.wdata_vld = sending_ff;

	// =====================================
	// wishbone slave; writes at 0x0 cmd, 0x4 params, 0xc irq enable (irq clear is a write at 0x8)
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_ff <= 1'b0;
			rd_ff <= 32'h0;
			cmd_ff <= 8'h00;
			go_ff <= 1'b0;
			feat_ff <= 16'h0;
			scnt_ff <= 16'h0;
			dh_ff <= 8'h00;
			lba_ff <= 24'h0;
			en_ff <= 2'b00;
		end else begin
			ack_ff <= wr || rd;
			go_ff <= 1'b0;
			if (wr) begin
				if (wb_adr_i == apmc_pkg::REG_CMD) begin
					cmd_ff <= wb_dat_i[7:0];
					feat_ff <= wb_dat_i[31:16];
					go_ff <= 1'b1;
				end else if (wb_adr_i == apmc_pkg::REG_PARAM) begin
					scnt_ff <= wb_dat_i[15:0];
					dh_ff <= wb_dat_i[23:16];
				end else if (wb_adr_i == apmc_pkg::REG_IRQ_STS) begin
					en_ff <= wb_dat_i[1:0];
				end
			end
			if (rd) begin
				if (wb_adr_i == apmc_pkg::REG_STAT) begin
					rd_ff <= {tf.scnt_out, tf.error, tf.status};
				end else if (wb_adr_i == apmc_pkg::REG_IRQ_STS) begin
					rd_ff <= {28'h0, en_ff, sts_ff};
				end else if (wb_adr_i == apmc_pkg::REG_PARAM) begin
					rd_ff <= {8'h00, dh_ff, scnt_ff};
				end else begin
					rd_ff <= 32'h0;
				end
			end
			if (wr && wb_adr_i == apmc_pkg::REG_CMD) begin
				lba_ff <= 24'h0;
			end
		end
	end

	// =====================================
	// sector payload for trim and format
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= 10'h0;
			sending_ff <= 1'b0;
		end else if (go_ff && (cmd_ff == apmc_pkg::OP_DSM || cmd_ff == apmc_pkg::OP_FORMAT)) begin
			sending_ff <= 1'b1;
			cnt_ff <= 10'h0;
		end else if (done_ev) begin
			// a refused command never opens the data phase, so stop offering bytes
			sending_ff <= 1'b0;
		end else if (sending_ff && tf.wdata_rdy) begin
			cnt_ff <= 10'(cnt_ff + 10'h1);
			if (cnt_ff == 10'(apmc_pkg::BLOCK_BYTES - 10'h1)) begin
				sending_ff <= 1'b0;
			end
		end
	end

	// =====================================
	// sticky events: bit0 done, bit1 error; set wins over clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sts_ff <= 2'b00;
			irq_d_ff <= 1'b0;
		end else begin
			irq_d_ff <= tf.intrq;
			sts_ff <= (sts_ff & ~((wr && wb_adr_i == apmc_pkg::REG_STAT) ? wb_dat_i[1:0] : 2'b00))
				| {err_ev, done_ev};
		end
	end
endmodule

/* File: verification/apmc_sva.sv */
`timescale 1ns/1ns
// ==========
// checks on the link between both ends
module apmc_sva (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] cmd,
	input wire logic cmd_vld,
	input wire logic [7:0] status,
	input wire logic [7:0] error,
	input wire logic [15:0] scnt_out,
	input wire logic intrq,
	input wire logic [1:0] pwr_mode_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// a request only counts when the device is not busy
	wire logic go = cmd_vld && !status[7];
	wire logic qry = go && (cmd == 8'h98 || cmd == 8'he5);
	a_cmd_sets_busy: assert property (go |=> status[7]) else $error("busy not set");
	a_query_done: assert property (qry |-> ##2 intrq && !status[7]) else $error("query late");
	a_idle_count: assert property (qry && pwr_mode_i == 2'd0 |-> ##2 scnt_out[7:0] == 8'hff)
		else $error("idle count wrong");
	a_stby_count: assert property (qry && pwr_mode_i != 2'd0 |-> ##2 scnt_out[7:0] == 8'h00)
		else $error("standby count wrong");
	a_diag_done: assert property (go && cmd == 8'h90 |-> ##2 intrq) else $error("diag late");
	a_busy_no_irq: assert property (status[7] |-> !intrq) else $error("irq while busy");
	a_ready_seek: assert property ($rose(intrq) && !status[0] |-> status[6] && status[4])
		else $error("ready or seek bit low");
	a_abort_code: assert property ($rose(intrq) && status[0] |-> error == 8'h04)
		else $error("abort code wrong");
	a_irq_holds: assert property (intrq && !cmd_vld |=> intrq) else $error("irq dropped");
	c_query: cover property (qry);
	c_ext_flush: cover property (go && cmd == 8'hea);
	c_abort: cover property ($rose(intrq) && status[0]);
endmodule

/* File: verification/test_apmc.sv */
`timescale 1ns/1ns
// ==========
// bench joining host end and device end
module test_apmc;
	logic clk, rst_b, cyc, stb, we, irq, ack, mfail, fsup;
	logic [3:0] adr;
	logic [31:0] dat, rdat, e, m;
	logic [1:0] pwr;
	logic [7:0] dcode;
	logic [47:0] dirty, flba, fl_lba;
	logic tgo, fgo;
	logic [8:0] fcnt;
	logic [27:0] fstart;
	int tg_n, fg_n;
	logic [31:0] eq[$], mq[$];
	int bad_count, compares, i;
	int seed = 32'hc692;
	apmc_if tf();
	apmc_dev apmc_dev_i (.sys_clk_i(clk), .rst_b_i(rst_b), .tf(tf), .pwr_mode_i(pwr),
		.flush_supported_i(fsup), .diag_code_i(dcode), .cache_dirty_top_i(dirty),
		.media_fail_lba_i(flba), .media_fail_i(mfail), .trim_go_o(tgo), .flush_lba_o(fl_lba),
		.fmt_count_o(fcnt), .fmt_start_o(fstart), .fmt_go_o(fgo));
	apmc_host apmc_host_i (.sys_clk_i(clk), .rst_b_i(rst_b), .tf(tf), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq));
	apmc_sva apmc_sva_i (.sys_clk_i(clk), .rst_b_i(rst_b), .cmd(tf.cmd), .cmd_vld(tf.cmd_vld),
		.status(tf.status), .error(tf.error), .scnt_out(tf.scnt_out), .intrq(tf.intrq),
		.pwr_mode_i(pwr));
	always #2 clk = ~clk;
	// ==========
	// checking
	task chk(input string n, input logic [47:0] ex, input logic [47:0] g);
		compares++;
		if (g !== ex) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, ex, g);
		end
	endtask
	task print_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// read results are compared as they come back, oldest note first
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			e = eq.pop_front();
			m = mq.pop_front();
			chk("stat", e, rdat & m);
		end
	end
	// one-cycle pulses are counted so they can be checked after the command
	always @(posedge clk) begin
		if (tgo === 1'b1)
			tg_n++;
		if (fgo === 1'b1)
			fg_n++;
	end
	// ==========
	// bus and command tasks
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (n >= 100) begin
			bad_count++;
			print_verdict();
		end
		cyc <= 0;
		stb <= 0;
	endtask
	task rd(input logic [31:0] ex, input logic [31:0] mk);
		eq.push_back(ex);
		mq.push_back(mk);
		wb(0, 4'h8, 32'h0);
	endtask
	// sticky bits are cleared first so a stale interrupt cannot end the wait
	task issue(input logic [7:0] c, input logic [15:0] f, input logic [23:0] p);
		int n;
		wb(1, 4'h8, 32'h3);
		wb(1, 4'h4, {8'h0, p});
		wb(1, 4'h0, {f, 8'h0, c});
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) begin
			bad_count++;
			print_verdict();
		end
	endtask
	// ==========
	// scenarios
	initial begin
		clk = 0; rst_b = 0; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; pwr = 0;
		fsup = 1; dcode = 8'h01; dirty = 48'h40; flba = 0; mfail = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1;
		rd(32'h50, 32'hffff);
		wb(1, 4'hc, 32'h3);
		$display("reset test done");
		for (i = 0; i < 8; i++) begin
			pwr <= i[1:0];
			issue(i[2] ? 8'he5 : 8'h98, 16'h0, $random(seed));
			rd({8'h0, (i[1:0] == 2'd0) ? 8'hff : 8'h00, 16'h50}, 32'h00ff00ff);
		end
		wb(1, 4'hc, 32'h0);
		@(posedge clk);
		chk("irq masked", 0, irq);
		wb(1, 4'hc, 32'h3);
		@(posedge clk);
		chk("irq enabled", 1, irq);
		wb(1, 4'h8, 32'h3);
		@(posedge clk);
		chk("irq cleared", 0, irq);
		$display("power query test done");
		for (i = 1; i <= 5; i++) begin
			dcode <= i[7:0];
			issue(8'h90, 16'h0, $random(seed));
			rd({16'h0, i[7:0], 8'h50}, 32'hffff);
		end
		$display("diagnostic test done");
		fsup <= 0;
		issue(8'he7, 16'h0, 24'h0);
		rd(32'h0451, 32'hffff);
		fsup <= 1;
		issue(8'he7, 16'h0, 24'h0);
		rd(32'h50, 32'hff);
		flba <= 48'h1 + ({$random(seed)} % 48'h30);
		mfail <= 1;
		issue(8'hea, 16'h0, 24'h0);
		rd(32'h0451, 32'hffff);
		chk("fail lba", flba, tf.lba_out);
		chk("resume", flba + 48'h1, fl_lba);
		mfail <= 0;
		issue(8'hea, 16'h0, 24'h0);
		rd(32'h50, 32'hff);
		$display("flush test done");
		issue(8'h06, 16'h1, 24'h2);
		rd(32'h0451, 32'hffff);
		issue(8'h06, 16'h0, 24'h1);
		rd(32'h0451, 32'hffff);
		$display("trim refusal test done");
		issue(8'h06, 16'h1, 24'h1);
		rd(32'h50, 32'hff);
		chk("trim pulses", 1, tg_n);
		$display("trim test done");
		// format results are checked here, though software should avoid it
		issue(8'h50, 16'h0, 24'h450000);
		rd(32'h50, 32'hff);
		chk("fmt count zero", 9'h100, fcnt);
		chk("fmt start", 28'h5000000, fstart);
		chk("fmt pulses", 1, fg_n);
		issue(8'h50, 16'h0, 24'h4a0007);
		chk("fmt count", 9'h007, fcnt);
		chk("fmt start lba", 28'ha000000, fstart);
		issue(8'h50, 16'h0, 24'h030009);
		chk("fmt chs count", 9'h001, fcnt);
		chk("fmt start chs", 28'h3000000, fstart);
		chk("fmt pulses all", 3, fg_n);
		$display("format test done");
		repeat (4) @(posedge clk);
		print_verdict();
	end
endmodule
